/* design/dual_channel_pwm_unit.sv */
/*
  Two-channel pulse-width unit: shared 16-bit counter, per-channel fast/slow
  period, double-buffered 8-bit duty, force-high and general-purpose output.
  Assumes a word-indexed register port with byte enables, one-cycle strobes
  and read data in the cycle after the read strobe.
*/
// The register addresses and the plain strobed port were chosen for this implementation.
// Behaviour
// - both channels run from one 16-bit counter stepped by the prescaler clock.
// - fast period is 256 prescaler clocks, slow period is 32768.
// - channel A pin can show the counter's driving clock instead of its waveform.
// - after reset the counter runs from the core clock divided by two.
// - 3-bit select picks divide 2 to 128, code 111 picks the pin clock.
// - counter reads never disturb it; a word read is coherent.
// - counter resets to zero and takes writes only in freeze or test mode.
// - only counter bits 14 to 0 feed the channel period selection.
// - each channel has its own fast/slow select bit in control.
// - fast uses counter bits 7:0, slow uses bits 14:7.
// - duty zero stays low, 0x80 half high, 0xFF high 255 of 256 counts.
// - both 8-bit duty registers share one word, byte or word access.
// - force-high drives the pin high from the cycle end, except channel A while clock-out is on.
// - force-high bits are the two low force bits, at the control word.
// - a written duty is copied into the active buffer only at cycle end.
// - active duty buffers are read-only, byte or word readable.
// - duty and control registers reset to zero, read and write anytime.
// - control is the low byte of a word whose high byte is force.
// - with modulation disabled each pin drives its force-high bit.
// - reading the force-high bits returns the actual pin levels.
// - the force byte is reachable by byte or by word access.
`timescale 1ns/1ps
module dual_channel_pwm_unit import pwm_pkg::*; (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire reg_req_t reg_req_in,
  input wire logic freeze_in,
  input wire logic ext_clk_in,
  output logic [DATA_W-1:0] rdata_out,
  output logic pwm_first_out,
  output logic pwm_second_out
);

  unit_state_t st_r;
  unit_state_t st_nxt;
  logic tick;
  logic tap_level;
  logic [CHAN_N-1:0] eoc;
  logic [CHAN_N-1:0] slow;
  logic [CHAN_N-1:0] en;
  logic wr_cnt;
  logic wr_ctrl;
  logic wr_duty;

  // prescaler select comes straight from the control register
  prescale_tap u_tap (
    .core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .sel_in(st_r.ctrl[CTRL_SEL_MSB:CTRL_SEL_LSB]),
    .ext_clk_in(ext_clk_in),
    .tick_out(tick),
    .level_out(tap_level)
  );

  assign wr_cnt = reg_req_in.wr && (reg_req_in.addr == ADDR_COUNTER);
  assign wr_ctrl = reg_req_in.wr && (reg_req_in.addr == ADDR_CTRL);
  assign wr_duty = reg_req_in.wr && (reg_req_in.addr == ADDR_DUTY);

  // per-channel mode, enable and end-of-cycle strobe
  always_comb begin
    for (int i = 0; i < CHAN_N; i++) begin
      slow[i] = st_r.ctrl[CTRL_SF_A + i];
      en[i] = st_r.ctrl[CTRL_EN_A + i];
      // bit 15 never takes part in the period
      eoc[i] = tick && cycle_last(st_r.cnt, slow[i]);
    end
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata = DATA_ZERO;

    // shared counter; a write wins over the step in freeze/test mode
    if (wr_cnt && freeze_in) begin
      st_nxt.cnt = merge_bytes(st_r.cnt, reg_req_in.wdata, reg_req_in.be);
    end else if (tick) begin
      st_nxt.cnt = st_r.cnt + CNT_ONE;
    end

    // control low byte, force high byte, each lane on its own
    if (wr_ctrl && reg_req_in.be[LANE_LO]) begin
      st_nxt.ctrl = reg_req_in.wdata[7:0];
    end
    if (wr_ctrl && reg_req_in.be[LANE_HI]) begin
      st_nxt.force_hi = reg_req_in.wdata[FORCE_LSB +: CHAN_N];
    end

    // duty A is the high byte, duty B the low byte
    if (wr_duty && reg_req_in.be[LANE_HI]) begin
      st_nxt.duty[0] = reg_req_in.wdata[15:8];
    end
    if (wr_duty && reg_req_in.be[LANE_LO]) begin
      st_nxt.duty[1] = reg_req_in.wdata[7:0];
    end

    for (int i = 0; i < CHAN_N; i++) begin
      // stored duty, not the same-cycle write, goes into the buffer
      if (eoc[i]) begin
        st_nxt.act[i] = st_r.duty[i];
      end
      // force waits for the cycle end so no runt pulse appears
      if (!en[i] || eoc[i]) begin
        st_nxt.force_act[i] = st_r.force_hi[i];
      end
      if (!en[i]) begin
        st_nxt.pins[i] = st_r.force_hi[i];
      end else if (st_r.force_act[i]) begin
        st_nxt.pins[i] = 1'b1;
      end else begin
        // duty 0 never high, 0xFF high for 255 of 256 slices
        st_nxt.pins[i] = slice_of(st_r.cnt, slow[i]) < st_r.act[i];
      end
    end
    // clock-out overrides channel A only while modulation is on
    if (en[0] && st_r.ctrl[CTRL_CLKOUT_A]) begin
      st_nxt.pins[0] = tap_level;
    end

    // whole word captured in one edge, so a word read is coherent
    if (reg_req_in.rd) begin
      case (reg_req_in.addr)
        ADDR_COUNTER: begin
          st_nxt.rdata = st_r.cnt;
        end
        ADDR_CTRL: begin
          st_nxt.rdata = {FORCE_PAD, st_r.pins, st_r.ctrl};
        end
        ADDR_DUTY: begin
          st_nxt.rdata = {st_r.duty[0], st_r.duty[1]};
        end
        ADDR_ACTIVE: begin
          st_nxt.rdata = {st_r.act[0], st_r.act[1]};
        end
        default: begin
          st_nxt.rdata = DATA_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r.cnt <= CNT_RESET;
      st_r.ctrl <= CTRL_RESET;
      st_r.force_hi <= FORCE_RESET;
      st_r.duty <= {DUTY_RESET, DUTY_RESET};
      st_r.act <= {DUTY_RESET, DUTY_RESET};
      st_r.force_act <= FORCE_RESET;
      st_r.pins <= FORCE_RESET;
      st_r.rdata <= DATA_ZERO;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata_out = st_r.rdata;
  assign pwm_first_out = st_r.pins[0];
  assign pwm_second_out = st_r.pins[1];

  // checks on the block's own behaviour
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!arst_n_in);

  sequence s_force_pending_a;
    en[0] && !eoc[0] && st_r.force_hi[0] && !st_r.force_act[0];
  endsequence

  sequence s_force_taken_a;
    en[0] && !st_r.ctrl[CTRL_CLKOUT_A] && eoc[0] && st_r.force_hi[0] && !reg_req_in.wr;
  endsequence

  a_cnt_step: assert property (
    tick && !(wr_cnt && freeze_in) |=> st_r.cnt == $past(st_r.cnt) + CNT_ONE)
    else $error("counter did not step on tick");

  a_cnt_read_only: assert property (
    !tick && !(wr_cnt && freeze_in) |=> $stable(st_r.cnt))
    else $error("counter changed without tick or freeze write");

  a_div2_rate: assert property (
    st_r.ctrl[CTRL_SEL_MSB:CTRL_SEL_LSB] == 3'h0 && tick |=> !tick)
    else $error("divide-by-two tap ticked twice in a row");

  a_duty_buffer: assert property (
    $changed(st_r.act[0]) |-> $past(eoc[0]))
    else $error("active duty A changed away from cycle end");

  a_duty_load: assert property (
    eoc[1] |=> st_r.act[1] == $past(st_r.duty[1]))
    else $error("active duty B not loaded at cycle end");

  a_active_ro: assert property (
    reg_req_in.wr && reg_req_in.addr == ADDR_ACTIVE && eoc == 2'h0 |=> $stable(st_r.act))
    else $error("active duty changed by a write");

  a_duty_byte: assert property (
    wr_duty && reg_req_in.be == 2'h2
    |=> st_r.duty[0] == $past(reg_req_in.wdata[15:8]) && $stable(st_r.duty[1]))
    else $error("high byte write to duty word went wrong");

  a_zero_duty: assert property (
    en[1] && !st_r.force_act[1] && st_r.act[1] == DUTY_RESET |=> !pwm_second_out)
    else $error("duty zero drove channel B high");

  a_slice_compare: assert property (
    en[1] && !st_r.force_act[1]
    |=> pwm_second_out == ($past(slice_of(st_r.cnt, slow[1])) < $past(st_r.act[1])))
    else $error("channel B level does not follow slice compare");

  a_force_wait: assert property (
    s_force_pending_a |=> !st_r.force_act[0])
    else $error("force on channel A taken before cycle end");

  a_force_high: assert property (
    s_force_taken_a |=> st_r.force_act[0] ##1 pwm_first_out)
    else $error("forced channel A not high after cycle end");

  a_gpio_drive: assert property (
    !en[1] |=> pwm_second_out == $past(st_r.force_hi[1]))
    else $error("disabled channel B not driving its force bit");

  a_force_readback: assert property (
    reg_req_in.rd && reg_req_in.addr == ADDR_CTRL
    |=> rdata_out[FORCE_LSB +: CHAN_N] == $past({pwm_second_out, pwm_first_out}))
    else $error("force bits do not read back pin levels");

  a_ctrl_write: assert property (
    wr_ctrl && reg_req_in.be[LANE_LO] |=> st_r.ctrl == $past(reg_req_in.wdata[7:0]))
    else $error("control write not stored");

endmodule

/* design/prescale_tap.sv */
/*
  Prescaler tap: divides the core clock by 2..128 or follows an external
  count clock, giving a one-cycle tick and a square level of the chosen rate.
  Assumes the external clock pin is already synchronous to core_clk_in.
*/
`timescale 1ns/1ps
module prescale_tap import pwm_pkg::*; (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic [2:0] sel_in,
  input wire logic ext_clk_in,
  output logic tick_out,
  output logic level_out
);

  presc_state_t st_r;
  presc_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.div = st_r.div + PRESC_ONE;
    st_nxt.ext_prev = ext_clk_in;
    if (sel_in == SEL_EXT) begin
      // rising edge of the pin clock counts once
      st_nxt.tick = ext_clk_in & ~st_r.ext_prev;
      st_nxt.level = ext_clk_in;
    end else begin
      // low sel+1 bits all ones: once every 2^(sel+1) cycles
      st_nxt.tick = (st_r.div & tap_mask(sel_in)) == tap_mask(sel_in);
      st_nxt.level = st_r.div[sel_in];
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r <= '{div: PRESC_RESET, ext_prev: 1'b0, tick: 1'b0, level: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick_out = st_r.tick;
  assign level_out = st_r.level;

endmodule

/* design/pwm_pkg.sv */
/*
  Shared constants, carrier types and helper functions for the two-channel
  pulse-width unit and its prescaler tap. Assumes a single 100 MHz core clock
  and a register port addressed by 16-bit word index.
*/
package pwm_pkg;

  localparam int CNT_W = 16;
  localparam int DUTY_W = 8;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int PRESC_W = 7;
  localparam int CHAN_N = 2;

  // word addresses of the register port
  localparam logic [ADDR_W-1:0] ADDR_COUNTER = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_DUTY = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_ACTIVE = 4'h3;

  // pwm_control bit positions
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_SEL_MSB = 2;
  localparam int CTRL_SF_A = 3;
  localparam int CTRL_CLKOUT_A = 5;
  localparam int CTRL_EN_A = 6;

  // byte lanes of a word
  localparam int LANE_LO = 0;
  localparam int LANE_HI = 1;
  localparam int FORCE_LSB = 8;

  localparam logic [2:0] SEL_EXT = 3'h7;
  localparam logic [2:0] SEL_TOP = 3'h6;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DUTY_RESET = 8'h00;
  localparam logic [1:0] FORCE_RESET = 2'h0;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] DATA_ZERO = 16'h0000;
  localparam logic [5:0] FORCE_PAD = 6'h00;
  localparam logic [6:0] PRESC_RESET = 7'h00;
  localparam logic [6:0] PRESC_ONE = 7'h01;
  localparam logic [6:0] PRESC_FULL = 7'h7F;
  localparam logic [7:0] FAST_LAST = 8'hFF;
  localparam logic [14:0] SLOW_LAST = 15'h7FFF;
  localparam int SLOW_LSB = 7;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0] be;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [PRESC_W-1:0] div;
    logic ext_prev;
    logic tick;
    logic level;
  } presc_state_t;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [7:0] ctrl;
    logic [CHAN_N-1:0] force_hi;
    logic [CHAN_N-1:0][DUTY_W-1:0] duty;
    logic [CHAN_N-1:0][DUTY_W-1:0] act;
    logic [CHAN_N-1:0] force_act;
    logic [CHAN_N-1:0] pins;
    logic [DATA_W-1:0] rdata;
  } unit_state_t;

  function automatic logic [PRESC_W-1:0] tap_mask(input logic [2:0] sel);
    tap_mask = PRESC_FULL >> (SEL_TOP - sel);
  endfunction

  function automatic logic [DUTY_W-1:0] slice_of(input logic [CNT_W-1:0] cnt, input logic slow);
    slice_of = slow ? cnt[SLOW_LSB +: DUTY_W] : cnt[DUTY_W-1:0];
  endfunction

  function automatic logic cycle_last(input logic [CNT_W-1:0] cnt, input logic slow);
    cycle_last = slow ? (cnt[14:0] == SLOW_LAST) : (cnt[DUTY_W-1:0] == FAST_LAST);
  endfunction

  function automatic logic [DATA_W-1:0] merge_bytes(input logic [DATA_W-1:0] old,
                                                   input logic [DATA_W-1:0] nw,
                                                   input logic [1:0] be);
    merge_bytes = old;
    if (be[LANE_LO]) begin
      merge_bytes[7:0] = nw[7:0];
    end
    if (be[LANE_HI]) begin
      merge_bytes[15:8] = nw[15:8];
    end
  endfunction

endpackage

/* verification/dual_channel_pwm_unit_tb.sv */
/*
  Self-checking bench for the two-channel pulse-width unit: register port,
  prescaler rates, duty, double buffering, force-high and pin-as-output use.
  Assumes the unit's one-cycle read latency and one-cycle pin lag.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module dual_channel_pwm_unit_tb import pwm_pkg::*;;
  logic core_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic freeze_in = 1'b0;
  logic ext_clk_in = 1'b0;
  reg_req_t req = '0;
  logic [15:0] rdata_out;
  logic pa;
  logic pb;
  logic [15:0] v;
  int n_mismatch = 0;
  int tests_run = 0;

  always #5 core_clk_in = ~core_clk_in;

  dual_channel_pwm_unit dut_u (
    .core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .reg_req_in(req),
    .freeze_in(freeze_in),
    .ext_clk_in(ext_clk_in),
    .rdata_out(rdata_out),
    .pwm_first_out(pa),
    .pwm_second_out(pb)
  );

  task automatic results();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic [1:0] b);
    @(posedge core_clk_in);
    req <= '{addr: a, wdata: d, be: b, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk_in);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk_in);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge core_clk_in);
    req.rd <= 1'b0;
    #1 d = rdata_out;
  endtask

  task automatic chk_rd(input logic [3:0] a, input logic [15:0] e);
    logic [15:0] d;
    rd(a, d);
    `CHK(d, e)
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask

  // one rising edge on the pin clock, held high one cycle
  task automatic pulse();
    @(posedge core_clk_in);
    ext_clk_in <= 1'b1;
    @(posedge core_clk_in);
    ext_clk_in <= 1'b0;
  endtask

  // counter only takes writes while freeze is high at the write edge
  task automatic fw(input logic [15:0] d);
    @(posedge core_clk_in);
    freeze_in <= 1'b1;
    wr(ADDR_COUNTER, d, 2'b11);
    freeze_in <= 1'b0;
  endtask

  // two counter reads whose sampling edges are gap cycles apart
  task automatic rate(input int gap, input logic [15:0] e);
    logic [15:0] c0;
    logic [15:0] c1;
    rd(ADDR_COUNTER, c0);
    repeat (gap - 2) @(posedge core_clk_in);
    rd(ADDR_COUNTER, c1);
    `CHK(c1 - c0, e)
  endtask

  task automatic t_reset();
    chk_rd(ADDR_CTRL, 16'h0000);
    chk_rd(ADDR_DUTY, 16'h0000);
    chk_rd(4'hF, 16'h0000);
    rate(16, 16'h0008);
  endtask

  task automatic t_gpio();
    wr(ADDR_CTRL, 16'h0300, 2'b10);
    cyc(3);
    `CHK({pb, pa}, 2'b11)
    chk_rd(ADDR_CTRL, 16'h0300);
    wr(ADDR_CTRL, 16'h0100, 2'b11);
    cyc(3);
    `CHK({pb, pa}, 2'b01)
    chk_rd(ADDR_CTRL, 16'h0100);
    wr(ADDR_CTRL, 16'h0000, 2'b10);
  endtask

  task automatic t_presc();
    logic [15:0] c0;
    logic [15:0] c1;
    for (int s = 0; s < 7; s++) begin
      wr(ADDR_CTRL, {13'h0000, 3'(s)}, 2'b01);
      rate((2 << s) * 8, 16'h0008);
    end
    wr(ADDR_CTRL, 16'h0007, 2'b01);
    cyc(4);
    rd(ADDR_COUNTER, c0);
    repeat (5) pulse();
    cyc(4);
    rd(ADDR_COUNTER, c1);
    `CHK(c1 - c0, 16'h0005)
  endtask

  task automatic t_duty();
    logic [7:0] tab [3][2] = '{'{8'h00, 8'h80}, '{8'h80, 8'hFF}, '{8'hFF, 8'h01}};
    // four-state counts, so an unknown pin level poisons the sum instead of reading as 0
    logic [15:0] na;
    logic [15:0] nb;
    wr(ADDR_CTRL, 16'h00C0, 2'b01);
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_DUTY, {tab[k][0], tab[k][1]}, 2'b11);
      cyc(600); // new duty lands only at a period end
      na = 16'h0000;
      nb = 16'h0000;
      for (int i = 0; i < 512; i++) begin
        cyc(1);
        na += 16'(pa);
        nb += 16'(pb);
      end
      `CHK(na, {7'h00, tab[k][0], 1'b0})
      `CHK(nb, {7'h00, tab[k][1], 1'b0})
    end
  endtask

  // pin clock idle, so the counter moves only when the bench says
  task automatic t_static();
    wr(ADDR_CTRL, 16'h00D7, 2'b01);
    cyc(4);
    rd(ADDR_COUNTER, v);
    wr(ADDR_COUNTER, 16'h1234, 2'b11);
    chk_rd(ADDR_COUNTER, v);
    fw(16'h00FF);
    chk_rd(ADDR_COUNTER, 16'h00FF);
    chk_rd(ADDR_COUNTER, 16'h00FF);
    wr(ADDR_DUTY, 16'h00FF, 2'b11);
    wr(ADDR_DUTY, 16'hFF80, 2'b01);
    // high lane only: duty B must keep its value
    wr(ADDR_DUTY, 16'h00AA, 2'b10);
    chk_rd(ADDR_DUTY, 16'h0080);
    chk_rd(ADDR_ACTIVE, 16'hFF01);
    wr(ADDR_ACTIVE, 16'h5A5A, 2'b11);
    chk_rd(ADDR_ACTIVE, 16'hFF01);
    wr(ADDR_CTRL, 16'h01D7, 2'b10);
    cyc(3);
    `CHK(pa, 1'b0)
    chk_rd(ADDR_CTRL, 16'h00D7);
    pulse();
    cyc(3);
    `CHK(pa, 1'b1)
    chk_rd(ADDR_ACTIVE, 16'h0001);
    chk_rd(ADDR_CTRL, 16'h01D7);
    wr(ADDR_CTRL, 16'h00D7, 2'b10);
    fw(16'h7FFF);
    pulse();
    cyc(3);
    `CHK(pb, 1'b1)
    `CHK(pa, 1'b0)
    chk_rd(ADDR_ACTIVE, 16'h0080);
    fw(16'h4000);
    cyc(3);
    `CHK(pb, 1'b0)
    fw(16'hBF80);
    cyc(3);
    `CHK(pb, 1'b1)
  endtask

  task automatic t_clkout();
    int n;
    logic prev;
    wr(ADDR_CTRL, 16'h0061, 2'b01);
    cyc(8);
    n = 0;
    prev = pa;
    for (int i = 0; i < 64; i++) begin
      cyc(1);
      if (pa !== prev) begin
        n++;
      end
      prev = pa;
    end
    `CHK(n, 32)
  endtask

  // hang guard, far beyond the longest run
  initial begin
    #1000000;
    n_mismatch++;
    results();
  end

  initial begin
    repeat (2) @(posedge core_clk_in);
    arst_n_in <= 1'b1;
    t_reset();
    t_gpio();
    t_presc();
    t_duty();
    t_static();
    t_clkout();
    results();
  end
endmodule
